// ---- logic/csm_pkg.sv ----
// shared constants and types of the clock select and monitor block
package csm_pkg;

  // system clock rate and detector threshold
  localparam int CLK_FREQ_HZ   = 250_000_000;
  localparam int DET_THRESH_HZ = 2_000;
  localparam int DET_CYCLES    = CLK_FREQ_HZ / DET_THRESH_HZ;

  // clock sources
  localparam int NUM_SRC = 5;
  localparam int SRC_W   = 3;
  localparam int DIV_W   = 4;
  localparam logic [SRC_W-1:0] SRC_RC     = 3'h0;
  localparam logic [SRC_W-1:0] SRC_XTAL48 = 3'h1;
  localparam logic [SRC_W-1:0] SRC_RTC    = 3'h2;
  localparam logic [SRC_W-1:0] SRC_DEBUG  = 3'h3;
  localparam logic [SRC_W-1:0] SRC_EXT    = 3'h4;

  // sleep clock sources
  localparam logic [1:0] RTC_RC32   = 2'h0;
  localparam logic [1:0] RTC_XTAL32 = 2'h1;
  localparam logic [1:0] RTC_PIN    = 2'h2;

  // register offsets
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_GATE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DIV  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STBY = 8'h14;

  // control register fields
  localparam int CTRL_SEL_LSB  = 0;
  localparam int CTRL_RTC_LSB  = 3;
  localparam int CTRL_PIN_LSB  = 5;
  localparam int CTRL_DET_EN   = 7;
  localparam int CTRL_DRST_EN  = 8;
  localparam int CTRL_MON_MAIN = 9;
  localparam int CTRL_MON_RTC  = 10;
  localparam int CTRL_RC_FAST  = 11;
  localparam int CTRL_W        = 12;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h780;
  localparam logic [NUM_SRC-1:0] GATE_RESET = 5'h1F;

  // status and mask fields
  localparam int ST_FAULT_MAIN  = 0;
  localparam int ST_FAULT_RTC   = 1;
  localparam int ST_SWITCH_DONE = 2;
  localparam int ST_WAKE        = 3;
  localparam int ST_EVT_W       = 4;
  localparam int ST_CUR_LSB     = 8;
  localparam int ST_BUSY        = 11;

  // source switch sequencer states
  typedef enum logic [2:0] {
    SW_RUN    = 3'b001,
    SW_DRAIN  = 3'b010,
    SW_SETTLE = 3'b100
  } csm_sw_state_t;

endpackage

// ---- logic/csm_prescaler.sv ----
// gated prescaler for one sampled clock source
`timescale 1ns/10ps
module csm_prescaler #(
  parameter int DIV_W = 4
) (
  // clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  // source and settings
  input  wire logic             src_in,
  input  wire logic             gate_en_in,
  input  wire logic [DIV_W-1:0] ratio_in,
  // divided clock
  output logic                  clk_out
);

  logic             src_prev_reg;
  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] cnt_next;
  logic             clk_next;
  wire              src_rise  = src_in & ~src_prev_reg;
  wire              cnt_last  = (cnt_reg == ratio_in - {{(DIV_W-1){1'b0}}, 1'b1});
  wire              pass_thru = (ratio_in == '0);

  // ratio zero passes the source, else output toggles every ratio rising edges
  always_comb begin
    cnt_next = cnt_reg;
    clk_next = clk_out;
    if (!gate_en_in) begin
      cnt_next = '0;
      clk_next = 1'b0;
    end else if (pass_thru) begin
      cnt_next = '0;
      clk_next = src_in;
    end else if (src_rise) begin
      cnt_next = cnt_last ? '0 : cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
      clk_next = cnt_last ? ~clk_out : clk_out;
    end
  end

  // state flops
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      src_prev_reg <= 1'b0;
      cnt_reg      <= '0;
      clk_out      <= 1'b0;
    end else begin
      src_prev_reg <= src_in;
      cnt_reg      <= cnt_next;
      clk_out      <= clk_next;
    end
  end

endmodule

// ---- logic/csm_clock_ctrl.sv ----
// clock source selection, gating, prescaling and clock loss detection
// What this block does
// - After startup the main core clock runs from the internal RC oscillator, 3 or 12 MHz.
// - Normal operation takes the main core clock from the 48 MHz crystal.
// - Standby clock comes from 32 kHz RC, 32 kHz crystal or a digital pin.
// - Debug mode may select the debug port clock pin as main core clock.
// - The external clock pin is also a selectable main core clock source.
// - Every generated clock has its own software gate.
// - Every clock has its own software-set prescaler.
// - Detector watches main clock, sleep clock or both during sleep (sleep_mode_in) only; standby alone does not enable it.
// - Monitored clock below about 2 kHz causes a chip reset.
// - Detector and its reset are on after reset; software may disable each.
// - Standby stops the processor clock; interrupt unit clock keeps running.
// - Supply drop below power-on level resets the whole clock logic.
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module csm_clock_ctrl
  import csm_pkg::*;
#(
  parameter int DET_LIMIT = csm_pkg::DET_CYCLES
) (
  // clock and resets
  input  wire logic                        clk_sys_in,
  input  wire logic                        rst_in,
  input  wire logic                        supply_por_in,
  // sampled clock sources
  input  wire logic                        rc_osc_in,
  input  wire logic                        xtal48_in,
  input  wire logic                        rc32_in,
  input  wire logic                        xtal32_in,
  input  wire logic [3:0]                  digital_pin_in,
  input  wire logic                        debug_port_clock_pin_in,
  input  wire logic                        external_clock_pin_in,
  // power mode
  input  wire logic                        sleep_mode_in,
  input  wire logic                        irq_wake_in,
  // register port
  input  wire logic [csm_pkg::ADDR_W-1:0]  reg_addr_in,
  input  wire logic [31:0]                 reg_wdata_in,
  input  wire logic                        reg_wr_in,
  input  wire logic                        reg_rd_in,
  output logic [31:0]                      reg_rdata_out,
  // clocks out
  output logic                             main_core_clock_out,
  output logic                             cpu_clock_out,
  output logic                             irq_unit_clock_out,
  output logic                             sleep_clock_out,
  output logic                             rc_fast_sel_out,
  // reset and interrupt
  output logic                             chip_reset_out,
  output logic                             irq_out
);

  import csm_pkg::*;

  // register storage
  logic [CTRL_W-1:0]        ctrl_reg;
  logic [NUM_SRC-1:0]       gate_reg;
  logic [NUM_SRC*DIV_W-1:0] div_reg;
  logic [ST_EVT_W-1:0]      stat_reg;
  logic [ST_EVT_W-1:0]      mask_reg;
  logic                     standby_reg;
  logic [SRC_W-1:0]         cur_sel_reg;
  csm_sw_state_t            sw_state_reg;
  csm_sw_state_t            sw_state_next;
  logic                     main_clock_next;
  logic [31:0]              rdata_next;
  logic [1:0]               det_fault;
  logic [1:0]               mon_prev_reg;
  logic [31:0]              det_cnt_reg [2];

  // global reset folds in the supply drop
  // supply drop reset
  wire rst_int = rst_in | supply_por_in;

  // write decode
  wire wr_ctrl = reg_wr_in && (reg_addr_in == OFS_CTRL);
  wire wr_gate = reg_wr_in && (reg_addr_in == OFS_GATE);
  wire wr_div  = reg_wr_in && (reg_addr_in == OFS_DIV);
  wire wr_stat = reg_wr_in && (reg_addr_in == OFS_STAT);
  wire wr_mask = reg_wr_in && (reg_addr_in == OFS_MASK);
  wire wr_stby = reg_wr_in && (reg_addr_in == OFS_STBY);

  // control fields
  wire [SRC_W-1:0] sel_req   = ctrl_reg[CTRL_SEL_LSB +: SRC_W];
  wire [1:0]       rtc_src   = ctrl_reg[CTRL_RTC_LSB +: 2];
  wire [1:0]       pin_sel   = ctrl_reg[CTRL_PIN_LSB +: 2];
  wire             det_en    = ctrl_reg[CTRL_DET_EN];
  wire             drst_en   = ctrl_reg[CTRL_DRST_EN];
  wire             sel_legal = (sel_req < SRC_W'(NUM_SRC));
  wire             sw_req    = sel_legal && (sel_req != cur_sel_reg);

  // sleep clock source mux, pin source limited to digital pins 0..3
  // sleep clock mux
  wire rtc_raw = (rtc_src == RTC_RC32)   ? rc32_in :
                 (rtc_src == RTC_XTAL32) ? xtal32_in :
                 (rtc_src == RTC_PIN)    ? digital_pin_in[pin_sel] : 1'b0;

  // raw source vector, index is the source code
  // source vector
  wire [NUM_SRC-1:0] src_raw = {external_clock_pin_in, debug_port_clock_pin_in,
                                rtc_raw, xtal48_in, rc_osc_in};
  wire [NUM_SRC-1:0] src_div;

  // one gate and one prescaler per source
  // gate and prescaler
  for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
    csm_prescaler #(
      .DIV_W (DIV_W)
    ) u_presc (
      .clk_sys_in (clk_sys_in),
      .rst_in     (rst_int),
      .src_in     (src_raw[g]),
      .gate_en_in (gate_reg[g]),
      .ratio_in   (div_reg[g*DIV_W +: DIV_W]),
      .clk_out    (src_div[g])
    );
  end

  // glitch-free switch: finish high phase, park low, wait new source low
  // glitch-free switch
  always_comb begin
    sw_state_next = sw_state_reg;
    unique case (sw_state_reg)
      SW_RUN: begin
        if (sw_req) sw_state_next = SW_DRAIN;
      end
      SW_DRAIN: begin
        if (!main_core_clock_out) sw_state_next = SW_SETTLE;
      end
      SW_SETTLE: begin
        if (!src_div[cur_sel_reg]) sw_state_next = SW_RUN;
      end
    endcase
  end

  // main clock follows the current source in run, and in drain until it falls
  assign main_clock_next = ((sw_state_reg == SW_RUN) ||
                            ((sw_state_reg == SW_DRAIN) && main_core_clock_out)) ?
                           src_div[cur_sel_reg] : 1'b0;

  // clock loss detectors on the raw main source and the sleep clock
  // watch main and sleep clocks
  wire [1:0] mon_src = {rtc_raw, src_raw[cur_sel_reg]};
  wire [1:0] mon_en  = {ctrl_reg[CTRL_MON_RTC], ctrl_reg[CTRL_MON_MAIN]};
  for (genvar m = 0; m < 2; m++) begin : g_det
    wire edge_seen = mon_src[m] & ~mon_prev_reg[m];
    assign det_fault[m] = det_en && mon_en[m] && sleep_mode_in &&
                          (det_cnt_reg[m] == 32'(DET_LIMIT - 1));
    always_ff @(posedge clk_sys_in) begin
      if (rst_int) begin
        mon_prev_reg[m] <= 1'b0;
        det_cnt_reg[m]  <= '0;
      end else begin
        mon_prev_reg[m] <= mon_src[m];
        det_cnt_reg[m]  <= (edge_seen || !sleep_mode_in || det_fault[m]) ? '0 :
                           det_cnt_reg[m] + 32'h1;
      end
    end
  end

  // sticky events, a new event wins over a write-one clear
  wire [ST_EVT_W-1:0] evt_set = {irq_wake_in & standby_reg,
                                 (sw_state_reg == SW_SETTLE) && !src_div[cur_sel_reg],
                                 det_fault[1], det_fault[0]};
  wire [ST_EVT_W-1:0] evt_clr = wr_stat ? reg_wdata_in[ST_EVT_W-1:0] : '0;
  wire [ST_EVT_W-1:0] stat_next = (stat_reg & ~evt_clr) | evt_set;

  // read mux, unmapped addresses read zero
  always_comb begin
    rdata_next = 32'h0;
    unique case (reg_addr_in)
      OFS_CTRL: rdata_next[CTRL_W-1:0] = ctrl_reg;
      OFS_GATE: rdata_next[NUM_SRC-1:0] = gate_reg;
      OFS_DIV:  rdata_next[NUM_SRC*DIV_W-1:0] = div_reg;
      OFS_STAT: begin
        rdata_next[ST_EVT_W-1:0] = stat_reg;
        rdata_next[ST_CUR_LSB +: SRC_W] = cur_sel_reg;
        rdata_next[ST_BUSY] = (sw_state_reg != SW_RUN);
      end
      OFS_MASK: rdata_next[ST_EVT_W-1:0] = mask_reg;
      OFS_STBY: rdata_next[0] = standby_reg;
      default:  rdata_next = 32'h0;
    endcase
  end

  // software registers; detector and its reset start enabled
  // detector on at reset
  always_ff @(posedge clk_sys_in) begin
    if (rst_int) begin
      ctrl_reg <= CTRL_RESET;
      gate_reg <= GATE_RESET;
      div_reg  <= '0;
      mask_reg <= '0;
      stat_reg <= '0;
    end else begin
      if (wr_ctrl) ctrl_reg <= reg_wdata_in[CTRL_W-1:0];
      if (wr_gate) gate_reg <= reg_wdata_in[NUM_SRC-1:0];
      if (wr_div)  div_reg  <= reg_wdata_in[NUM_SRC*DIV_W-1:0];
      if (wr_mask) mask_reg <= reg_wdata_in[ST_EVT_W-1:0];
      stat_reg <= stat_next;
    end
  end

  // processor standby: set by software, left on a wake interrupt
  // standby entry and exit
  always_ff @(posedge clk_sys_in) begin
    if (rst_int) begin
      standby_reg <= 1'b0;
    end else if (irq_wake_in) begin
      standby_reg <= 1'b0;
    end else if (wr_stby) begin
      standby_reg <= reg_wdata_in[0];
    end
  end

  // switch sequencer, reset selects the RC oscillator
  // reset to RC source
  always_ff @(posedge clk_sys_in) begin
    if (rst_int) begin
      sw_state_reg <= SW_RUN;
      cur_sel_reg  <= SRC_RC;
    end else begin
      sw_state_reg <= sw_state_next;
      // an illegal code written during a drain keeps the old source
      if ((sw_state_reg == SW_DRAIN) && !main_core_clock_out && sel_legal) begin
        cur_sel_reg <= sel_req;
      end
    end
  end

  // clock outputs; interrupt unit clock never stops for standby
  // clock split
  always_ff @(posedge clk_sys_in) begin
    if (rst_int) begin
      main_core_clock_out <= 1'b0;
      cpu_clock_out       <= 1'b0;
      irq_unit_clock_out  <= 1'b0;
      sleep_clock_out     <= 1'b0;
      rc_fast_sel_out     <= 1'b0;
      irq_out             <= 1'b0;
      reg_rdata_out       <= 32'h0;
    end else begin
      main_core_clock_out <= main_clock_next;
      cpu_clock_out       <= main_clock_next & ~standby_reg;
      irq_unit_clock_out  <= main_clock_next;
      sleep_clock_out     <= src_div[SRC_RTC];
      rc_fast_sel_out     <= ctrl_reg[CTRL_RC_FAST];
      irq_out             <= |(stat_next & mask_reg);
      reg_rdata_out       <= reg_rd_in ? rdata_next : 32'h0;
    end
  end

  // chip reset from supply drop or an enabled detector trip
  // chip reset
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      chip_reset_out <= 1'b0;
    end else begin
      chip_reset_out <= supply_por_in | (drst_en & (|det_fault));
    end
  end

  // checks
  AST_RESET_RC: assert property (
    @(posedge clk_sys_in) $fell(rst_int) |-> (cur_sel_reg == SRC_RC) && det_en && drst_en)
    else $error("reset did not select the RC source with detector on");

  AST_SETTLE_LOW: assert property (
    @(posedge clk_sys_in) disable iff (rst_int)
    (sw_state_reg == SW_DRAIN) && !main_core_clock_out |=> !main_core_clock_out [*2])
    else $error("main clock not parked low across a switch");

  AST_DET_TRIP: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (|det_fault) && drst_en |=> chip_reset_out)
    else $error("detector trip did not reset the chip");

  AST_DET_QUIET: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    !supply_por_in && !drst_en |=> !chip_reset_out)
    else $error("chip reset with detector reset disabled");

  AST_DET_OFF: assert property (
    @(posedge clk_sys_in) disable iff (rst_int)
    !sleep_mode_in |-> det_fault == 2'b00)
    else $error("detector tripped outside sleep");

  AST_STANDBY: assert property (
    @(posedge clk_sys_in) disable iff (rst_int)
    standby_reg && !irq_wake_in && !wr_stby |=> !cpu_clock_out && standby_reg)
    else $error("processor clock running in standby");

  AST_IRQ_CLK: assert property (
    @(posedge clk_sys_in) disable iff (rst_int)
    irq_unit_clock_out == main_core_clock_out)
    else $error("interrupt unit clock differs from main clock");

  AST_POR: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    supply_por_in |=> chip_reset_out ##1 (cur_sel_reg == SRC_RC))
    else $error("supply drop did not reset the block");

  AST_GATE: assert property (
    @(posedge clk_sys_in) disable iff (rst_int)
    !gate_reg[SRC_RTC] [*3] |-> !sleep_clock_out)
    else $error("gated sleep clock still toggling");

endmodule

// ---- verification/csm_osc_model.sv ----
// oscillator and pin clock model feeding the clock select block
`timescale 1ns/10ps
module csm_osc_model (
  // clock, reset and oscillator stop
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic       stop_in,
  // sampled source levels
  output logic            rc_osc_out,
  output logic            xtal48_out,
  output logic            rc32_out,
  output logic            xtal32_out,
  output logic [3:0]      digital_pin_out,
  output logic            debug_pin_out,
  output logic            ext_pin_out
);
  int tick_reg;
  // time base; a stopped oscillator freezes at its last level
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      tick_reg <= 0;
    end else if (!stop_in) begin
      tick_reg <= tick_reg + 1;
    end
  end
  // distinct half periods so every source is recognisable by rate, except rc32 and digital pin 2, which share 7
  assign rc_osc_out = 1'((tick_reg / 3) % 2);
  assign xtal48_out = 1'((tick_reg / 2) % 2);
  assign rc32_out = 1'((tick_reg / 7) % 2);
  assign xtal32_out = 1'((tick_reg / 11) % 2);
  assign digital_pin_out = {1'((tick_reg / 8) % 2), 1'((tick_reg / 7) % 2),
                            1'((tick_reg / 6) % 2), 1'((tick_reg / 5) % 2)};
  assign debug_pin_out = 1'((tick_reg / 4) % 2);
  assign ext_pin_out = 1'((tick_reg / 9) % 2);
endmodule

// ---- verification/soc_clock_select_and_monitor_tb_top.sv ----
// self-checking bench of the clock select and monitor block
`timescale 1ns/10ps
module soc_clock_select_and_monitor_tb_top;
  import csm_pkg::*;
  localparam int LIM = 50;
  logic              clk_sys_in = 1'b0;
  logic              rst_in = 1'b1;
  logic              por = 1'b0;
  logic              stop = 1'b0;
  logic              sleep = 1'b0;
  logic              wake = 1'b0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [31:0]       wdata = 32'h0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [31:0]       rdata;
  logic              rc, x48, r32, x32, dbg, ext, fast, chip_rst, irq;
  logic [3:0]        pins;
  logic [3:0]        clks;
  logic [31:0]       v;
  logic [7:0]        ofs [5] = '{OFS_CTRL, OFS_GATE, OFS_DIV, OFS_MASK, 8'h20};
  logic [31:0]       rstv [5] = '{32'h780, 32'h1F, 32'h0, 32'h0, 32'h0};
  int                hm [5] = '{3, 2, 7, 4, 9};
  int                hs [3] = '{7, 11, 8};
  int                miscompares = 0;
  int                n_compared = 0;
  int                c;
  int                trips = 0;

  // system clock
  always #2 clk_sys_in = ~clk_sys_in;
  // count chip reset cycles
  always @(posedge clk_sys_in) if (chip_rst === 1'b1) trips++;

  csm_osc_model i_csm_osc_model (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .stop_in(stop),
    .rc_osc_out(rc), .xtal48_out(x48), .rc32_out(r32), .xtal32_out(x32),
    .digital_pin_out(pins), .debug_pin_out(dbg), .ext_pin_out(ext));

  csm_clock_ctrl #(.DET_LIMIT(LIM)) i_csm_clock_ctrl (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .supply_por_in(por), .rc_osc_in(rc), .xtal48_in(x48),
    .rc32_in(r32), .xtal32_in(x32), .digital_pin_in(pins), .debug_port_clock_pin_in(dbg),
    .external_clock_pin_in(ext), .sleep_mode_in(sleep), .irq_wake_in(wake),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .main_core_clock_out(clks[0]), .cpu_clock_out(clks[2]),
    .irq_unit_clock_out(clks[3]), .sleep_clock_out(clks[1]), .rc_fast_sel_out(fast),
    .chip_reset_out(chip_rst), .irq_out(irq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  // rising edges of clock output k over n cycles, then compared within one edge
  task automatic edges(input int k, input int n, input int e, input string what);
    logic p;
    c = 0;
    p = clks[k];
    repeat (n) begin
      @(posedge clk_sys_in);
      #1;
      if (clks[k] === 1'b1 && p === 1'b0) c++;
      p = clks[k];
    end
    n_compared++;
    if (c < e - 1 || c > e + 1) begin
      miscompares++;
      $display("unexpected at %0t: %s edges %0d want %0d", $time, what, c, e);
    end
  endtask

  task automatic wait_switch();
    int i;
    i = 0;
    v = 32'h0;
    while (v[ST_SWITCH_DONE] !== 1'b1 && i < 100) begin
      rd_reg(OFS_STAT);
      i++;
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watchdog well beyond the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    // reset values, unmapped address last
    for (int i = 0; i < 5; i++) begin
      rd_reg(ofs[i]);
      chk(v, rstv[i], "reset value");
    end
    edges(0, 240, 240 / 6, "rc main");
    wr_reg(OFS_CTRL, 32'hF80);
    // trim output follows the control register one cycle later
    @(posedge clk_sys_in);
    #1;
    chk(32'(fast), 32'h1, "rc trim");
    // walk every main source after RC (codes 1 to 4), with switch done status and its clear
    for (int s = 1; s < 5; s++) begin
      wr_reg(OFS_CTRL, 32'h780 | 32'(s));
      wait_switch();
      chk(v & 32'hF0F, (32'(s) << 8) | 32'h4, "switch");
      edges(0, 240, 240 / (2 * hm[s]), "main rate");
      wr_reg(OFS_STAT, 32'h4);
      rd_reg(OFS_STAT);
      chk(v & 32'h4, 32'h0, "done clear");
    end
    // prescale and gate the external pin source
    wr_reg(OFS_DIV, 32'h10000);
    edges(0, 240, 240 / 36, "divided");
    wr_reg(OFS_GATE, 32'h0F);
    edges(0, 240, 0, "gated");
    wr_reg(OFS_GATE, 32'h1F);
    wr_reg(OFS_DIV, 32'h0);
    // sleep clock sources, pin 3 for the pin choice
    for (int s = 0; s < 3; s++) begin
      wr_reg(OFS_CTRL, 32'h7E4 | 32'(s << 3));
      edges(1, 240, 240 / (2 * hs[s]), "sleep rate");
    end
    // sleep clock gate off stops the sleep clock output
    wr_reg(OFS_GATE, 32'h1B);
    edges(1, 240, 0, "sleep gated");
    wr_reg(OFS_GATE, 32'h1F);
    // processor standby keeps the interrupt unit clocked
    wr_reg(OFS_STBY, 32'h1);
    edges(2, 60, 0, "cpu stopped");
    edges(3, 72, 4, "irq unit clock");
    @(posedge clk_sys_in);
    wake <= 1'b1;
    @(posedge clk_sys_in);
    wake <= 1'b0;
    rd_reg(OFS_STAT);
    chk(v & 32'h8, 32'h8, "wake status");
    edges(2, 72, 4, "cpu running");
    // interrupt raised, masked and cleared
    wr_reg(OFS_MASK, 32'h8);
    repeat (2) @(posedge clk_sys_in);
    chk(32'(irq), 32'h1, "irq raised");
    wr_reg(OFS_MASK, 32'h0);
    repeat (2) @(posedge clk_sys_in);
    chk(32'(irq), 32'h0, "irq masked");
    wr_reg(OFS_MASK, 32'h8);
    wr_reg(OFS_STAT, 32'h8);
    repeat (2) @(posedge clk_sys_in);
    chk(32'(irq), 32'h0, "irq cleared");
    // detector quiet while clocks run, trips once they stop
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    sleep <= 1'b1;
    trips = 0;
    repeat (150) @(posedge clk_sys_in);
    chk(32'(trips), 32'h0, "no false trip");
    stop <= 1'b1;
    repeat (LIM + 30) @(posedge clk_sys_in);
    chk(32'(trips > 0), 32'h1, "clock loss reset");
    rd_reg(OFS_STAT);
    chk(v & 32'h3, 32'h3, "both faults");
    // reset of the detector disabled, then the detector itself
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    stop <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    wr_reg(OFS_CTRL, 32'h680);
    trips = 0;
    stop <= 1'b1;
    repeat (LIM + 30) @(posedge clk_sys_in);
    chk(32'(trips), 32'h0, "reset disabled");
    rd_reg(OFS_STAT);
    chk(v & 32'h1, 32'h1, "fault still flagged");
    wr_reg(OFS_CTRL, 32'h600);
    wr_reg(OFS_STAT, 32'h3);
    repeat (LIM + 30) @(posedge clk_sys_in);
    rd_reg(OFS_STAT);
    chk(v & 32'h3, 32'h0, "detector disabled");
    @(posedge clk_sys_in);
    stop <= 1'b0;
    sleep <= 1'b0;
    // supply drop resets the clock logic and the chip
    wr_reg(OFS_CTRL, 32'hF80);
    @(posedge clk_sys_in);
    por <= 1'b1;
    @(posedge clk_sys_in);
    por <= 1'b0;
    #1;
    chk(32'(chip_rst), 32'h1, "supply reset");
    rd_reg(OFS_CTRL);
    chk(v, 32'h780, "ctrl after supply reset");
    chk(32'(fast), 32'h0, "trim after supply reset");
    // an unused select code keeps the current source
    wr_reg(OFS_CTRL, 32'h787);
    rd_reg(OFS_STAT);
    chk(v & 32'hF00, 32'h0, "illegal select ignored");
    tally_and_finish();
  end
endmodule
